// ### design/cvsd_pkg.sv
package cvsd_pkg;
    // Depth of the history shift register used for coincidence
    localparam int unsigned HIST_BITS = 3;
    localparam int unsigned FIFO_WIDTH = 1;
    localparam int unsigned FIFO_DEPTH = 16;
    // Pin inputs pass three synchroniser flip-flops, then a settle register
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic [HIST_BITS-1:0] HIST_RESET = 3'h2;
    localparam logic [HIST_BITS-1:0] HIST_ALL_ONES = 3'h7;
    localparam logic [HIST_BITS-1:0] HIST_ALL_ZEROS = 3'h0;

    // Mode and bit pins as sampled at one falling bit-clock edge
    typedef struct packed {
        logic encode;
        logic comp_high;
        logic data_in;
    } bit_sample_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_RUN = 2'h2
    } seq_state_e;
endpackage : cvsd_pkg

// ### design/cvsd_bit_sequencer.sv
// How it works
// RULE1: Encode high loads comparator result each falling edge
// RULE2: Encode low loads serial data input instead
// RULE3: Coincidence low when history all ones/zeros
// RULE4: Serial output changes only on falling edge
// RULE5: Encode output inverts analog-above-feedback comparison
// RULE6: Decode output is inverse of sampled data
// RULE7: Output looped to input toggles every clock
// RULE8: Slope polarity follows comparison or data bit
// RULE9: Bit clock equals serial bit rate
// RULE10: No input gives alternating one-zero output
// RULE11: Select low lets logic inject patterns
// RULE12: Shift in newest, drop oldest, then evaluate
`timescale 1ns/1ps

module cvsd_bit_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointers wrap by overflow, so only powers of two are served
    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_fifo_shape
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_ready = (count != (AW+1)'(DEPTH));
    assign o_valid = (count != '0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rd_ptr];

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (push && !pop) begin
                count <= count + (AW+1)'(1);
            end else if (pop && !push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end
endmodule : cvsd_bit_fifo

module cvsd_bit_sequencer #(
    parameter int unsigned FIFO_DEPTH = cvsd_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Codec pins, asynchronous to the core clock
    input wire logic i_bit_clk,
    input wire logic i_encode,
    input wire logic i_comp_high,
    input wire logic i_data_in,
    // Pin outputs
    output logic o_data_out,
    output logic o_coincidence_n,
    output logic o_slope_into,
    // Decoded bit stream towards the core
    output logic o_bit_valid,
    input wire logic i_bit_ready,
    output logic o_bit,
    output logic o_overflow
);
    localparam int unsigned SN = cvsd_pkg::SYNC_STAGES;
    localparam int unsigned HN = cvsd_pkg::HIST_BITS;

    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("fifo depth too small");
    end

    // Three-stage synchronisers; the first stage feeds only the second
    logic [SN-1:0] sync_clk;
    logic [SN-1:0] sync_enc;
    logic [SN-1:0] sync_cmp;
    logic [SN-1:0] sync_din;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sync_clk <= '0;
            sync_enc <= '0;
            sync_cmp <= '0;
            sync_din <= '0;
        end else begin
            sync_clk <= {sync_clk[SN-2:0], i_bit_clk};
            sync_enc <= {sync_enc[SN-2:0], i_encode};
            sync_cmp <= {sync_cmp[SN-2:0], i_comp_high};
            sync_din <= {sync_din[SN-2:0], i_data_in};
        end
    end

    // Settled levels count once the second and third stages agree
    logic bclk;
    logic enc;
    logic cmp;
    logic din;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            bclk <= 1'h0;
            enc <= 1'h0;
            cmp <= 1'h0;
            din <= 1'h0;
        end else begin
            if (sync_clk[SN-1] == sync_clk[SN-2]) begin
                bclk <= sync_clk[SN-1];
            end
            if (sync_enc[SN-1] == sync_enc[SN-2]) begin
                enc <= sync_enc[SN-1];
            end
            if (sync_cmp[SN-1] == sync_cmp[SN-2]) begin
                cmp <= sync_cmp[SN-1];
            end
            if (sync_din[SN-1] == sync_din[SN-2]) begin
                din <= sync_din[SN-1];
            end
        end
    end

    logic bclk_q;
    logic fall;
    cvsd_pkg::bit_sample_s smp;
    logic new_bit;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            bclk_q <= 1'h0;
        end else begin
            bclk_q <= bclk;
        end
    end

    // One bit per bit-clock period; the channel clock sets the rate
    assign fall = bclk_q && !bclk; // RULE9
    assign smp = '{encode: enc, comp_high: cmp, data_in: din};
    // Comparator high means analog input above feedback
    assign new_bit = smp.encode ? smp.comp_high : smp.data_in; // RULE1 RULE2 RULE11

    // Sequencer leaves idle at the first falling edge; pins and queue update on every fall regardless of state
    cvsd_pkg::seq_state_e state;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= cvsd_pkg::ST_IDLE;
        end else begin
            case (state)
                cvsd_pkg::ST_IDLE: begin
                    if (fall) begin
                        state <= cvsd_pkg::ST_RUN;
                    end
                end
                cvsd_pkg::ST_RUN: begin
                    state <= cvsd_pkg::ST_RUN;
                end
                default: begin
                    state <= cvsd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    logic [HN-1:0] hist;
    logic [HN-1:0] next_hist;

    assign next_hist = {hist[HN-2:0], new_bit}; // RULE12

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            hist <= cvsd_pkg::HIST_RESET;
            o_data_out <= 1'h1;
            o_slope_into <= 1'h0;
            o_coincidence_n <= 1'h1;
        end else if (fall) begin // RULE4
            hist <= next_hist; // RULE12
            // Output is the inverted sign; with a loop-back it toggles
            o_data_out <= ~new_bit; // RULE5 RULE6 RULE7 RULE10
            o_slope_into <= new_bit; // RULE8
            o_coincidence_n <= !((next_hist == cvsd_pkg::HIST_ALL_ONES) ||
                                 (next_hist == cvsd_pkg::HIST_ALL_ZEROS)); // RULE3
        end
    end

    // Every sampled bit is queued for the core; a full queue drops and flags
    logic push_ready;
    logic push_valid;

    assign push_valid = fall && (state != cvsd_pkg::ST_IDLE || fall);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_overflow <= 1'h0;
        end else if (push_valid && !push_ready) begin
            o_overflow <= 1'h1;
        end
    end

    cvsd_bit_fifo #(
        .WIDTH(cvsd_pkg::FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_valid(push_valid),
        .o_ready(push_ready),
        .i_data(new_bit),
        .o_valid(o_bit_valid),
        .i_ready(i_bit_ready),
        .o_data(o_bit)
    );
endmodule : cvsd_bit_sequencer

// ### tb/cvsd_bit_sequencer_assertions.sv
`timescale 1ns/1ps
module cvsd_bit_sequencer_assertions #(parameter int unsigned FIFO_DEPTH = 16) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_bit_clk,
    input wire logic i_encode,
    input wire logic i_comp_high,
    input wire logic i_data_in,
    input wire logic o_data_out,
    input wire logic o_coincidence_n,
    input wire logic o_slope_into,
    input wire logic o_bit_valid,
    input wire logic i_bit_ready,
    input wire logic o_bit,
    input wire logic o_overflow
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence bit_moved;
        $changed(o_data_out);
    endsequence
    chk_slope_match: assert property (o_slope_into == !o_data_out)
        else $error("slope not tied to bit");
    // Pins are held well clear of the fall, so four cycles back is the sampled level
    chk_encode_bit: assert property (bit_moved and $past(i_encode, 4) |->
        o_data_out == !$past(i_comp_high, 4)) else $error("encode bit");
    chk_decode_bit: assert property (bit_moved and !$past(i_encode, 4) |->
        o_data_out == !$past(i_data_in, 4)) else $error("decode bit");
    chk_output_hold: assert property (i_bit_clk [*8] |=>
        $stable({o_data_out, o_coincidence_n, o_slope_into})) else $error("output moved");
    chk_coin_clear: assert property ($rose(o_coincidence_n) |-> bit_moved)
        else $error("coincidence cleared");
    chk_coin_set: assert property ($fell(o_coincidence_n) |-> $stable(o_data_out))
        else $error("coincidence set");
    chk_fifo_hold: assert property (o_bit_valid && !i_bit_ready |=>
        o_bit_valid && $stable(o_bit)) else $error("fifo head moved");
    chk_overflow_sticky: assert property (o_overflow |=> o_overflow)
        else $error("overflow dropped");
endmodule : cvsd_bit_sequencer_assertions
bind cvsd_bit_sequencer cvsd_bit_sequencer_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) chk_i (.*);

// ### tb/cvsd_channel_model.sv
`timescale 1ns/1ps
module cvsd_channel_model (
    input wire logic i_core_clk,
    input wire logic i_loop,
    input wire logic i_tx_bit,
    input wire logic i_loop_bit,
    output logic o_bit_clk,
    output logic o_data_in
);
    logic [4:0] phase = 5'h0;
    initial o_bit_clk = 1'h1;
    initial o_data_in = 1'h0;
    // Data moves on the rise, half a bit away from the sampling fall
    always @(posedge i_core_clk) begin
        phase <= (phase == 5'h13) ? 5'h0 : phase + 5'h1;
        o_bit_clk <= phase < 5'ha;
        if (phase == 5'h0) o_data_in <= i_loop ? i_loop_bit : i_tx_bit;
    end
endmodule : cvsd_channel_model

// ### tb/cvsd_bit_sequencer_tb.sv
`timescale 1ns/1ps
module cvsd_bit_sequencer_tb;
    logic clk = 1'h0, rst = 1'h1, enc = 1'h0, cmp = 1'h0, tx = 1'h0, lp = 1'h0, rdy = 1'h1;
    logic bclk, din, dout, coin_n, slope, bv, bo, ovf, b;
    logic [2:0] hist = cvsd_pkg::HIST_RESET;
    logic [3:0] rows [6] = '{4'hc, 4'h9, 4'hb, 4'h5, 4'h2, 4'h1};
    int mismatches = 0, n_compared = 0;
    initial forever #2 clk = ~clk;
    cvsd_channel_model chan (.i_core_clk(clk), .i_loop(lp), .i_tx_bit(tx), .i_loop_bit(dout),
        .o_bit_clk(bclk), .o_data_in(din));
    cvsd_bit_sequencer uut (.i_core_clk(clk), .i_rst(rst), .i_bit_clk(bclk), .i_encode(enc),
        .i_comp_high(cmp), .i_data_in(din), .o_data_out(dout), .o_coincidence_n(coin_n),
        .o_slope_into(slope), .o_bit_valid(bv), .i_bit_ready(rdy), .o_bit(bo), .o_overflow(ovf));
    task automatic chk(string what, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // Inputs move 8 cycles after a fall, far from the next sampling fall
    task automatic step(logic e, logic c, logic t);
        @(negedge clk);
        enc = e;
        cmp = c;
        tx = t;
        b = e ? c : (lp ? !hist[0] : t);
        @(negedge bclk);
        repeat (8) @(negedge clk);
        hist = {hist[1:0], b};
        chk("data_out", !b, dout);
        chk("slope_into", b, slope);
        chk("coincidence_n", hist != 3'h7 && hist != 3'h0, coin_n);
    endtask : step
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'h0;
        @(negedge bclk);
        repeat (8) @(negedge clk);
        // The first fall after release takes the idle decode input, a zero
        hist = {hist[1:0], 1'h0};
        chk("first_out", 1'h1, dout);
        chk("first_coincidence_n", 1'h1, coin_n);
        foreach (rows[i]) begin
            step(rows[i][3], rows[i][2], rows[i][1]);
            chk("row_out", rows[i][0], dout);
        end
        // Comparator follows a feedback that steps toward a silent input
        repeat (4) step(1'h1, dout, 1'h0);
        $display("rows done");
        repeat (3) step(1'h1, 1'h1, 1'h0);
        lp = 1'h1;
        repeat (4) step(1'h0, 1'h0, 1'h0);
        lp = 1'h0;
        rdy = 1'h0;
        step(1'h0, 1'h0, 1'h0);
        repeat (15) step(1'h0, 1'h0, 1'h1);
        chk("overflow_at_full", 1'h0, ovf);
        step(1'h0, 1'h0, 1'h1);
        chk("overflow", 1'h1, ovf);
        chk("head_bit", 1'h0, bo);
        rdy = 1'h1;
        @(negedge clk);
        chk("next_bit", 1'h1, bo);
        repeat (19) @(negedge clk);
        chk("drained", 1'h0, bv);
        $display("loop and buffer done");
        rst = 1'h1;
        repeat (2) @(negedge clk);
        chk("reset_out", 1'h1, dout);
        chk("reset_overflow", 1'h0, ovf);
        chk("reset_coincidence_n", 1'h1, coin_n);
        chk("reset_slope", 1'h0, slope);
        chk("reset_valid", 1'h0, bv);
        $display("reset done");
        wrap_up();
    end
    // About 36 bits of 80 ns each; a generous margin above that
    initial begin
        #20000;
        mismatches++;
        wrap_up();
    end
endmodule : cvsd_bit_sequencer_tb
